// >>> tcs_clk_src.sv
module tcs_clk_src #(
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_count_pin,
  tcs_tick_if.src tif
);
  logic [DIV_W-1:0] div_reg;
  logic sync1_reg, sync2_reg, prev_reg;
  logic tick_c;

  if (DIV_W < tcs_pkg::TAP1024_MSB + 1) begin : g_chk
    $error("prescaler too narrow for the divide-by-1024 tap");
  end

  // ----------------------------------------
  // free-running prescaler
  // ----------------------------------------
  // never reset by the selection, only by aresetn or the prescaler reset pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || tif.psr) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // count pin synchroniser and edge memory
  // ----------------------------------------
  // prev keeps tracking while disabled, so a stable pin gives no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= ext_count_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // timer count clock pulse select
  always_comb begin
    unique case (tif.sel)
      tcs_pkg::CS_STOP: tick_c = 1'b0;
      tcs_pkg::CS_DIRECT: tick_c = 1'b1;
      tcs_pkg::CS_DIV8: tick_c = &div_reg[tcs_pkg::TAP8_MSB:0];
      tcs_pkg::CS_DIV64: tick_c = &div_reg[tcs_pkg::TAP64_MSB:0];
      tcs_pkg::CS_DIV256: tick_c = &div_reg[tcs_pkg::TAP256_MSB:0];
      tcs_pkg::CS_DIV1024: tick_c = &div_reg[tcs_pkg::TAP1024_MSB:0];
      tcs_pkg::CS_EXT_FALL: tick_c = prev_reg & ~sync2_reg;
      tcs_pkg::CS_EXT_RISE: tick_c = sync2_reg & ~prev_reg;
    endcase
  end
  assign tif.tick = tick_c;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  stop_no_tick_a: assert property (tif.sel == tcs_pkg::CS_STOP |-> !tick_c)
    else $error("tick while stopped");
  direct_tick_a: assert property (tif.sel == tcs_pkg::CS_DIRECT |-> tick_c)
    else $error("direct source missed a cycle");
  div64_phase_a: assert property ((tif.sel == tcs_pkg::CS_DIV64 && tick_c)
    |-> div_reg[5:0] == 6'h3f)
    else $error("divide-by-64 tick off phase");
  free_run_a: assert property (!tif.psr |=> div_reg == $past(div_reg) + 1'b1)
    else $error("prescaler did not advance");
  psr_clear_a: assert property (tif.psr |=> div_reg == '0)
    else $error("prescaler reset ignored");
  ext_rise_a: assert property (($rose(sync1_reg)
    && tif.sel == tcs_pkg::CS_EXT_RISE ##1 tif.sel == tcs_pkg::CS_EXT_RISE)
    |-> tick_c)
    else $error("rising pin edge gave no tick");
  ext_no_div_a: assert property ((tif.sel >= tcs_pkg::CS_EXT_FALL
    && sync2_reg == prev_reg) |-> !tick_c)
    else $error("external source ticked without an edge");
  div1024_c: cover property (tif.sel == tcs_pkg::CS_DIV1024 && tick_c);
  ext_fall_c: cover property (tif.sel == tcs_pkg::CS_EXT_FALL && tick_c);
endmodule : tcs_clk_src

// >>> tcs_pkg.sv
package tcs_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_CTRL_A = 5'h00;
  localparam logic [4:0] OFF_CTRL_B = 5'h04;
  localparam logic [4:0] OFF_CNT_LO = 5'h08;
  localparam logic [4:0] OFF_CNT_HI = 5'h0c;
  localparam logic [4:0] OFF_CMP_A = 5'h10;
  localparam logic [4:0] OFF_CMP_B = 5'h14;
  localparam logic [4:0] OFF_FLAGS = 5'h18;
  localparam logic [4:0] OFF_MASK = 5'h1c;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTC_BIT = 0;
  localparam int CAPEN_BIT = 1;
  localparam int WIDTH_BIT = 7;
  localparam int PSR_BIT = 3;
  localparam int OVF_BIT = 0;
  localparam int CMPA_BIT = 1;
  localparam int CMPB_BIT = 2;
  localparam int CAP_BIT = 3;
  // ----------------------------------------
  // prescaler taps, count limits and bus response codes
  // ----------------------------------------
  localparam int TAP8_MSB = 2;
  localparam int TAP64_MSB = 5;
  localparam int TAP256_MSB = 7;
  localparam int TAP1024_MSB = 9;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX8 = 8'hff;
  localparam logic [15:0] MAX16 = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // clock source selections, in field order
  // ----------------------------------------
  typedef enum logic [2:0] {
    CS_STOP, CS_DIRECT, CS_DIV8, CS_DIV64,
    CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
  } tcs_clk_sel_type;
endpackage : tcs_pkg

// >>> tcs_pulse_src.sv
module tcs_pulse_src (
  input wire logic aclk,
  input wire logic go,
  input wire logic [3:0] n,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // external count source
  // ----------------------------------------
  initial begin
    pin = 1'b0; // idle low and steady while software switches select
    busy = 1'b0;
  end
  // three cycles each half period, well above one system clock
  always begin
    @(posedge aclk);
    if (go) begin
      busy <= 1'b1;
      repeat (n) begin
        repeat (3) @(posedge aclk);
        pin <= 1'b1;
        repeat (3) @(posedge aclk);
        pin <= 1'b0;
      end
      repeat (3) @(posedge aclk);
      busy <= 1'b0;
    end
  end
endmodule : tcs_pulse_src

// >>> tcs_tick_if.sv
interface tcs_tick_if;
  tcs_pkg::tcs_clk_sel_type sel;
  logic psr;
  logic tick;
  modport src (input sel, input psr, output tick);
  modport sink (output sel, output psr, input tick);
endinterface : tcs_tick_if

// >>> tcs_timer.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
module tcs_timer #(
  parameter int ADDR_W = 5,
  parameter int DIV_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_count_pin,
  input wire logic capture_pin,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] irq_req
);
  if (ADDR_W < 5) begin : g_chk
    $error("address too narrow for the register map");
  end

  tcs_tick_if tif ();

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_strb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic clear_on_compare_bit, capture_enable_bit, counter_width_bit;
  tcs_pkg::tcs_clk_sel_type clock_source_select;
  logic psr_reg;
  logic [15:0] cnt_reg;
  logic [7:0] compare_value_a, compare_value_b;
  logic [3:0] flag_reg, mask_reg, irq_reg;
  logic block_reg;
  logic cap1_reg, cap2_reg, capprev_reg;

  logic wr_go, wr_en, cnt_lo_wr, cnt_hi_wr, cnt_wr, capture;
  logic [4:0] wr_off, rd_off;
  logic [7:0] top8;
  logic [15:0] cnt_next;
  logic reach_max, match_a, match_b;
  logic [3:0] flag_set, flag_clr;
  logic [31:0] rd_word;

  // ----------------------------------------
  // clock source
  // ----------------------------------------
  tcs_clk_src #(.DIV_W(DIV_W)) u_src (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_count_pin(ext_count_pin),
    .tif(tif)
  );
  assign tif.sel = clock_source_select;
  assign tif.psr = psr_reg;

  // ----------------------------------------
  // axi4-lite write channels
  // ----------------------------------------
  assign wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_en = wr_go && w_strb0_reg;
  assign wr_off = {aw_addr_reg[4:2], 2'b00};

  // address and data are held separately, so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_full_reg <= 1'b1;
      awready_reg <= 1'b0;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full_reg <= 1'b0;
      awready_reg <= 1'b1;
    end else begin
      awready_reg <= !aw_full_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_full_reg <= 1'b1;
      wready_reg <= 1'b0;
      w_byte_reg <= s_axi_wdata[7:0];
      w_strb0_reg <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_full_reg <= 1'b0;
      wready_reg <= 1'b1;
    end else begin
      wready_reg <= !w_full_reg;
    end
  end

  // response: addresses above the map answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= tcs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (aw_addr_reg >> 5) == '0 ? tcs_pkg::RESP_OKAY
                                             : tcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi4-lite read channels
  // ----------------------------------------
  assign rd_off = {s_axi_araddr[4:2], 2'b00};

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_off)
      tcs_pkg::OFF_CTRL_A: begin
        rd_word[tcs_pkg::CTC_BIT] = clear_on_compare_bit;
        rd_word[tcs_pkg::CAPEN_BIT] = capture_enable_bit;
        rd_word[tcs_pkg::WIDTH_BIT] = counter_width_bit;
      end
      tcs_pkg::OFF_CTRL_B: rd_word[2:0] = clock_source_select;
      tcs_pkg::OFF_CNT_LO: rd_word[7:0] = cnt_reg[7:0];
      tcs_pkg::OFF_CNT_HI: rd_word[7:0] = cnt_reg[15:8];
      tcs_pkg::OFF_CMP_A: rd_word[7:0] = compare_value_a;
      tcs_pkg::OFF_CMP_B: rd_word[7:0] = compare_value_b;
      tcs_pkg::OFF_FLAGS: rd_word[3:0] = flag_reg;
      tcs_pkg::OFF_MASK: rd_word[3:0] = mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one read at a time; arready returns when the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= tcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= (s_axi_araddr >> 5) == '0 ? rd_word : 32'h0000_0000;
      rresp_reg <= (s_axi_araddr >> 5) == '0 ? tcs_pkg::RESP_OKAY
                                              : tcs_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // prescaler reset is a write-one pulse and reads back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_on_compare_bit <= 1'b0;
      capture_enable_bit <= 1'b0;
      counter_width_bit <= 1'b0;
      clock_source_select <= tcs_pkg::CS_STOP;
      psr_reg <= 1'b0;
      mask_reg <= 4'h0;
    end else begin
      psr_reg <= wr_en && wr_off == tcs_pkg::OFF_CTRL_B
                 && w_byte_reg[tcs_pkg::PSR_BIT];
      if (wr_en && wr_off == tcs_pkg::OFF_CTRL_A) begin
        clear_on_compare_bit <= w_byte_reg[tcs_pkg::CTC_BIT];
        capture_enable_bit <= w_byte_reg[tcs_pkg::CAPEN_BIT];
        counter_width_bit <= w_byte_reg[tcs_pkg::WIDTH_BIT];
      end
      if (wr_en && wr_off == tcs_pkg::OFF_CTRL_B) begin
        clock_source_select <= tcs_pkg::tcs_clk_sel_type'(w_byte_reg[2:0]);
      end
      if (wr_en && wr_off == tcs_pkg::OFF_MASK) begin
        mask_reg <= w_byte_reg[3:0];
      end
    end
  end

  // ----------------------------------------
  // counter unit
  // ----------------------------------------
  assign cnt_lo_wr = wr_en && wr_off == tcs_pkg::OFF_CNT_LO;
  assign cnt_hi_wr = wr_en && wr_off == tcs_pkg::OFF_CNT_HI;
  assign cnt_wr = cnt_lo_wr || cnt_hi_wr;
  // compare a is TOP only in 8-bit clear-on-compare without capture
  assign top8 = (clear_on_compare_bit && !capture_enable_bit)
                ? compare_value_a : tcs_pkg::MAX8;

  always_comb begin
    cnt_next = cnt_reg;
    if (counter_width_bit) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (cnt_reg[7:0] == top8) begin
      cnt_next[7:0] = tcs_pkg::BOTTOM;
    end else begin
      cnt_next[7:0] = cnt_reg[7:0] + 1'b1;
    end
  end

  // a software write wins over the tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_wr) begin
      if (cnt_lo_wr) begin
        cnt_reg[7:0] <= w_byte_reg;
      end else begin
        cnt_reg[15:8] <= w_byte_reg;
      end
    end else if (tif.tick) begin
      cnt_reg <= cnt_next;
    end
  end

  // a counter write blocks compare matches up to and including the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (tif.tick) begin
      block_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // capture input and compare registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap1_reg <= 1'b0;
      cap2_reg <= 1'b0;
      capprev_reg <= 1'b0;
    end else begin
      cap1_reg <= capture_pin;
      cap2_reg <= cap1_reg;
      capprev_reg <= cap2_reg;
    end
  end
  assign capture = capture_enable_bit && cap2_reg && !capprev_reg;

  // a capture overrides a software write to the same compare byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value_a <= 8'h00;
      compare_value_b <= 8'h00;
    end else begin
      if (capture) begin
        compare_value_a <= cnt_reg[7:0];
      end else if (wr_en && wr_off == tcs_pkg::OFF_CMP_A) begin
        compare_value_a <= w_byte_reg;
      end
      if (capture && counter_width_bit) begin
        compare_value_b <= cnt_reg[15:8];
      end else if (wr_en && wr_off == tcs_pkg::OFF_CMP_B) begin
        compare_value_b <= w_byte_reg;
      end
    end
  end

  // ----------------------------------------
  // event flags and masked requests
  // ----------------------------------------
  assign reach_max = counter_width_bit ? cnt_next == tcs_pkg::MAX16
                                       : cnt_next[7:0] == tcs_pkg::MAX8;
  assign match_a = !capture_enable_bit && (counter_width_bit
    ? cnt_reg == {compare_value_b, compare_value_a}
    : cnt_reg[7:0] == compare_value_a);
  assign match_b = !counter_width_bit && cnt_reg[7:0] == compare_value_b;

  always_comb begin
    flag_set = 4'h0;
    flag_set[tcs_pkg::OVF_BIT] = tif.tick && !cnt_wr && reach_max;
    flag_set[tcs_pkg::CMPA_BIT] = tif.tick && !cnt_wr && !block_reg
                                  && match_a;
    flag_set[tcs_pkg::CMPB_BIT] = tif.tick && !cnt_wr && !block_reg
                                  && match_b;
    flag_set[tcs_pkg::CAP_BIT] = capture;
    flag_clr = (wr_en && wr_off == tcs_pkg::OFF_FLAGS) ? w_byte_reg[3:0]
                                                        : 4'h0;
  end

  // write one clears; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 4'h0;
      irq_reg <= 4'h0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clr) | flag_set;
      irq_reg <= flag_reg & mask_reg;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign irq_req = irq_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  stop_hold_a: assert property ((clock_source_select == tcs_pkg::CS_STOP
    && !cnt_wr) |=> $stable(cnt_reg))
    else $error("counter moved while stopped");
  wide_inc_a: assert property ((tif.tick && !cnt_wr && counter_width_bit)
    |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("16-bit count did not add one");
  top_wrap_a: assert property ((tif.tick && !cnt_wr && !counter_width_bit
    && cnt_reg[7:0] == top8) |=> cnt_reg[7:0] == tcs_pkg::BOTTOM)
    else $error("no wrap at TOP");
  ovf_set_a: assert property ((tif.tick && !cnt_wr && !counter_width_bit
    && cnt_reg[7:0] == 8'hfe && top8 == tcs_pkg::MAX8)
    |=> flag_reg[tcs_pkg::OVF_BIT] ##1 irq_reg[tcs_pkg::OVF_BIT]
        == mask_reg[tcs_pkg::OVF_BIT])
    else $error("overflow flag or request missing");
  cnt_read_a: assert property ((s_axi_arvalid && arready_reg
    && s_axi_araddr == ADDR_W'(tcs_pkg::OFF_CNT_LO))
    |=> rvalid_reg && rdata_reg[7:0] == $past(cnt_reg[7:0]))
    else $error("counter read returned wrong value");
  wr_prio_a: assert property ((cnt_lo_wr && tif.tick)
    |=> cnt_reg[7:0] == $past(w_byte_reg))
    else $error("tick beat a counter write");
  cmp16_a: assert property ((tif.tick && !cnt_wr && !block_reg
    && counter_width_bit && !capture_enable_bit
    && cnt_reg == {compare_value_b, compare_value_a})
    |=> flag_reg[tcs_pkg::CMPA_BIT])
    else $error("16-bit compare flag missing");
  set_wins_a: assert property ((flag_set[tcs_pkg::CAP_BIT]
    && flag_clr[tcs_pkg::CAP_BIT]) |=> flag_reg[tcs_pkg::CAP_BIT])
    else $error("clear beat a capture event");
  ctc_mode_a: assert property ((clear_on_compare_bit && !capture_enable_bit
    && !counter_width_bit) |-> top8 == compare_value_a)
    else $error("clear-on-compare TOP not compare a");
  bvalid_hold_a: assert property ((bvalid_reg && !s_axi_bready)
    |=> bvalid_reg [*2] or (bvalid_reg ##1 !bvalid_reg))
    else $error("write response dropped early");
  ovf_c: cover property (flag_set[tcs_pkg::OVF_BIT]);
  ctc_wrap_c: cover property (clear_on_compare_bit && tif.tick
    && cnt_reg[7:0] == compare_value_a && compare_value_a != 8'hff);
  capture_c: cover property (capture && counter_width_bit);
  slverr_c: cover property (wr_go && (aw_addr_reg >> 5) != '0);
endmodule : tcs_timer

// >>> timer_clock_select_counter_tb_top.sv
module timer_clock_select_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0, pin, busy;
  logic [3:0] n = 4'h1, irq_req, wstrb = 4'hf;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] v;
  logic [41:0] q[$];
  int err_total = 0, tests_run = 0, seed = 75753, cyc = 0, m;
  int divs[4] = '{8, 64, 256, 1024};
  localparam logic [5:0] A_CA = {1'b0, tcs_pkg::OFF_CTRL_A};
  localparam logic [5:0] A_CB = {1'b0, tcs_pkg::OFF_CTRL_B};
  localparam logic [5:0] A_LO = {1'b0, tcs_pkg::OFF_CNT_LO};
  localparam logic [5:0] A_HI = {1'b0, tcs_pkg::OFF_CNT_HI};
  localparam logic [5:0] A_CMPA = {1'b0, tcs_pkg::OFF_CMP_A};
  localparam logic [5:0] A_FL = {1'b0, tcs_pkg::OFF_FLAGS};
  localparam logic [5:0] A_MSK = {1'b0, tcs_pkg::OFF_MASK};
  localparam logic [1:0] OK = tcs_pkg::RESP_OKAY;
  always #2 aclk = ~aclk;
  tcs_pulse_src u_src (.aclk(aclk), .go(go), .n(n), .pin(pin), .busy(busy));
  tcs_timer #(.ADDR_W(6)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .ext_count_pin(pin), .capture_pin(1'b0), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_req(irq_req));
  // ----------------------------------------
  // bus tasks and checking
  // ----------------------------------------
  task automatic chk(input string nm, input logic [33:0] got,
      input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // each channel released only at its own handshake edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask : wr
  // the note is queued here; the monitor below compares it
  task automatic rd(input logic [5:0] a, input logic [7:0] e,
      input logic [7:0] mk, input logic [1:0] r);
    logic b;
    b = 1'b0;
    q.push_back({mk, r, 24'h0, e});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        b = 1'b1;
      end
    end
  endtask : rd
  // masked low byte lets a read accept a small range of counts
  always @(posedge aclk) begin
    logic [41:0] e;
    if (rvalid && rready) begin
      e = q.pop_front();
      chk("rdata", {rresp, rdata[31:8], rdata[7:0] & e[41:34]}, e[33:0]);
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // the longest prescaler case needs under 3000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_CB, 8'h00, 8'hff, OK);
    rd(6'h20, 8'h00, 8'hff, tcs_pkg::RESP_SLVERR);
    repeat (3) begin
      v = 8'($random(seed));
      wr(A_LO, v);
      repeat (20) @(posedge aclk);
      rd(A_LO, v, 8'hff, OK);
    end
    for (int k = 2; k < 6; k++) begin
      m = divs[k-2] + divs[k-2] / 2 - 4;
      wr(A_LO, 8'h00);
      // restart the divider while stopped, so the first tick is known
      wr(A_CB, 8'h08);
      wr(A_CB, 8'(k));
      repeat (m) @(posedge aclk);
      wr(A_CB, 8'h00);
      rd(A_LO, 8'h01, 8'hff, OK);
    end
    for (int k = 6; k < 8; k++) begin
      n <= 4'h1 + 4'($random(seed) & 7);
      wr(A_LO, 8'h00);
      wr(A_CB, 8'(k));
      go <= 1'b1;
      repeat (2) @(posedge aclk);
      go <= 1'b0;
      while (busy) @(posedge aclk);
      wr(A_CB, 8'h00);
      rd(A_LO, {4'h0, n}, 8'hff, OK);
    end
    wr(A_CA, 8'h80);
    wr(A_HI, 8'h12);
    wr(A_LO, 8'hff);
    wr(A_CB, 8'h01);
    wr(A_CB, 8'h00);
    rd(A_HI, 8'h13, 8'hff, OK);
    rd(A_LO, 8'h02, 8'hfe, OK);
    wr(A_CA, 8'h00);
    wr(A_FL, 8'h0f);
    wr(A_MSK, 8'h01);
    wr(A_LO, 8'hfe);
    wr(A_CB, 8'h01);
    wr(A_CB, 8'h00);
    rd(A_FL, 8'h01, 8'h01, OK);
    chk("irq_ovf", {30'h0, irq_req}, 34'h1);
    rd(A_LO, 8'h00, 8'hf8, OK);
    wr(A_FL, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq_clr", {33'h0, irq_req[0]}, 34'h0);
    wr(A_LO, 8'h00);
    wr(A_CMPA, 8'h03);
    wr(A_CA, 8'h01);
    wr(A_CB, 8'h01);
    repeat (40) @(posedge aclk);
    wr(A_CB, 8'h00);
    rd(A_LO, 8'h00, 8'hfc, OK);
    repeat (4) @(posedge aclk);
    tally_and_finish();
  end
endmodule : timer_clock_select_counter_tb_top
